// ---- common/lsp_pkg.sv ----
// Constants and types for the lane sample packer.
// Assumes one frame clock domain shared by sample source and link layer.
package lsp_pkg;
  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic [6:0] LSP_MODE_S12_L12_A = 7'h13;
  localparam logic [6:0] LSP_MODE_S12_L12_B = 7'h2A;
  localparam logic [6:0] LSP_MODE_D12_L12_A = 7'h14;
  localparam logic [6:0] LSP_MODE_D12_L12_B = 7'h2B;
  localparam logic [6:0] LSP_MODE_Q4_L4_A = 7'h15;
  localparam logic [6:0] LSP_MODE_Q4_L4_B = 7'h24;
  localparam logic [6:0] LSP_MODE_Q4_L8_A = 7'h16;
  localparam logic [6:0] LSP_MODE_Q4_L8_B = 7'h2E;
  localparam logic [6:0] LSP_MODE_Q8_L2_A = 7'h17;
  localparam logic [6:0] LSP_MODE_Q8_L2_B = 7'h26;
  localparam logic [6:0] LSP_MODE_Q8_L2_C = 7'h3D;
  localparam logic [6:0] LSP_MODE_Q8_L2_D = 7'h40;
  localparam logic [6:0] LSP_MODE_Q8_L2_E = 7'h45;
  localparam logic [6:0] LSP_MODE_Q8_L2_F = 7'h47;
  localparam logic [6:0] LSP_MODE_Q8_L4_A = 7'h18;
  localparam logic [6:0] LSP_MODE_Q8_L4_B = 7'h30;
  localparam logic [6:0] LSP_MODE_Q8_L4_C = 7'h3E;
  localparam logic [6:0] LSP_MODE_Q8_L4_D = 7'h41;
  localparam logic [6:0] LSP_MODE_Q8_L4_E = 7'h46;
  localparam logic [6:0] LSP_MODE_Q4_L16_A = 7'h19;
  localparam logic [6:0] LSP_MODE_Q4_L16_B = 7'h34;
  localparam logic [6:0] LSP_MODE_Q8_L8_A = 7'h1A;
  localparam logic [6:0] LSP_MODE_Q8_L8_B = 7'h36;
  localparam logic [6:0] LSP_MODE_Q8_L8_C = 7'h3F;
  localparam logic [6:0] LSP_MODE_Q8_L16 = 7'h1B;
  localparam logic [6:0] LSP_MODE_S12_L6 = 7'h20;
  localparam logic [6:0] LSP_MODE_D12_L6 = 7'h21;
  localparam logic [6:0] LSP_MODE_S8_L4 = 7'h22;
  // ****************************************
  // Widths
  // ****************************************
  localparam int LSP_LANES = 8;
  localparam int LSP_UNIT_W = 16;
  localparam int LSP_GROUP_W = LSP_LANES * LSP_UNIT_W;
  localparam int LSP_SAMPLES = 16;
  localparam int LSP_S12_W = 12;
  localparam int LSP_IQ_W = 15;
  localparam int LSP_OCT_W = 8;
  // ****************************************
  // Layout classes
  // ****************************************
  typedef enum logic [2:0] {
    LSP_LAY_NONE = 3'h0,
    LSP_LAY_S12 = 3'h1,
    LSP_LAY_D12 = 3'h3,
    LSP_LAY_IQ_OWN = 3'h2,
    LSP_LAY_IQ_PAIR = 3'h6,
    LSP_LAY_S8 = 3'h7
  } lsp_layout_t;
endpackage

// ---- core/lsp_frame_mapper.sv ----
// Lane sample packer: maps one frame of samples onto group A and B lanes.
// Assumes source data valid every frame clock and a static mode while linked.
//
// Notes on behaviour
// - 12-bit single, 12 lanes: even A, odd B
// - 12-bit values fill lane units contiguously
// - 12-bit dual, 12 lanes: channel per group
// - 15-bit words: I on A, Q on B
// - Decimate-4, 8 lanes: four I/Q, own flags
// - Decimate-8, 2 lanes: one I/Q word
// - Decimate-8, 4 lanes: two I/Q, own flags
// - Decimate-4, 16 lanes: pairs share flag index
// - Decimate-8, 8 lanes: four I/Q, own flags
// - Decimate-8, 16 lanes: eight I/Q, own flags
// - 12-bit single, 6 lanes: even A, odd B
// - 12-bit dual, 6 lanes: channel per group
// - 8-bit, 4 lanes: S0 A0, S2 A1, S1 B0, S3 B1
`timescale 1ns/10ps
`default_nettype none
module lsp_frame_mapper (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] lane_packing_mode_select,
  input wire logic [191:0] samples_12,
  input wire logic [127:0] samples_8,
  input wire logic [119:0] inphase_samples,
  input wire logic [119:0] quadrature_samples,
  input wire logic [7:0] inphase_overrange_flag,
  input wire logic [7:0] quadrature_overrange_flag,
  input wire logic sample_valid,
  output logic [127:0] group_a_lanes,
  output logic [127:0] group_b_lanes,
  output logic lanes_valid,
  output logic [7:0] lane_active
);
  // ****************************************
  // Mode decode
  // ****************************************
  logic [2:0] layout;
  logic [3:0] lane_count;
  logic [6:0] mode_decode;
  // Layout class and lanes per group for a mode code
  function automatic logic [6:0] lsp_decode(input logic [6:0] m);
    unique case (m)
      lsp_pkg::LSP_MODE_S12_L12_A, lsp_pkg::LSP_MODE_S12_L12_B: lsp_decode = {3'h1, 4'h6};
      lsp_pkg::LSP_MODE_D12_L12_A, lsp_pkg::LSP_MODE_D12_L12_B: lsp_decode = {3'h3, 4'h6};
      lsp_pkg::LSP_MODE_S12_L6: lsp_decode = {3'h1, 4'h3};
      lsp_pkg::LSP_MODE_D12_L6: lsp_decode = {3'h3, 4'h3};
      lsp_pkg::LSP_MODE_Q4_L4_A, lsp_pkg::LSP_MODE_Q4_L4_B,
      lsp_pkg::LSP_MODE_Q8_L4_A, lsp_pkg::LSP_MODE_Q8_L4_B, lsp_pkg::LSP_MODE_Q8_L4_C,
      lsp_pkg::LSP_MODE_Q8_L4_D, lsp_pkg::LSP_MODE_Q8_L4_E: lsp_decode = {3'h2, 4'h2};
      lsp_pkg::LSP_MODE_Q4_L8_A, lsp_pkg::LSP_MODE_Q4_L8_B,
      lsp_pkg::LSP_MODE_Q8_L8_A, lsp_pkg::LSP_MODE_Q8_L8_B,
      lsp_pkg::LSP_MODE_Q8_L8_C: lsp_decode = {3'h2, 4'h4};
      lsp_pkg::LSP_MODE_Q8_L2_A, lsp_pkg::LSP_MODE_Q8_L2_B, lsp_pkg::LSP_MODE_Q8_L2_C,
      lsp_pkg::LSP_MODE_Q8_L2_D, lsp_pkg::LSP_MODE_Q8_L2_E,
      lsp_pkg::LSP_MODE_Q8_L2_F: lsp_decode = {3'h2, 4'h1};
      lsp_pkg::LSP_MODE_Q8_L16: lsp_decode = {3'h2, 4'h8};
      lsp_pkg::LSP_MODE_Q4_L16_A, lsp_pkg::LSP_MODE_Q4_L16_B: lsp_decode = {3'h6, 4'h8};
      lsp_pkg::LSP_MODE_S8_L4: lsp_decode = {3'h7, 4'h2};
      default: lsp_decode = {3'h0, 4'h0};
    endcase
  endfunction
  // Mode registered on every clock cycle, valid or not; held static by the user
  logic [6:0] mode_reg;
  logic [6:0] mode_next;
  always_comb begin
    mode_next = lane_packing_mode_select;
  end
  assign mode_decode = lsp_decode(mode_reg);
  assign layout = mode_decode[6:4];
  assign lane_count = mode_decode[3:0];
  // ****************************************
  // 12-bit packing
  // ****************************************
  logic [95:0] even_words;
  logic [95:0] odd_words;
  logic [95:0] even_units;
  logic [95:0] odd_units;
  always_comb begin
    even_words = '0;
    odd_words = '0;
    for (int k = 0; k < 8; k++) begin
      if (layout == lsp_pkg::LSP_LAY_D12) begin
        even_words[95 - 12*k -: 12] = samples_12[12*k +: 12];
        odd_words[95 - 12*k -: 12] = samples_12[96 + 12*k +: 12];
      end else begin
        even_words[95 - 12*k -: 12] = samples_12[24*k +: 12];
        odd_words[95 - 12*k -: 12] = samples_12[24*k + 12 +: 12];
      end
    end
  end
  lsp_unit_pack u_pack_a (
    .words(even_words),
    .units(even_units)
  );
  lsp_unit_pack u_pack_b (
    .words(odd_words),
    .units(odd_units)
  );
  // ****************************************
  // Lane assembly
  // ****************************************
  logic [127:0] a_next;
  logic [127:0] b_next;
  logic [127:0] a_reg;
  logic [127:0] b_reg;
  logic valid_reg;
  logic valid_next;
  logic [7:0] active_next;
  logic [7:0] active_reg;
  always_comb begin
    a_next = '0;
    b_next = '0;
    active_next = '0;
    valid_next = sample_valid && (layout != lsp_pkg::LSP_LAY_NONE);
    for (int l = 0; l < 8; l++) begin
      if (l < int'(lane_count)) begin
        active_next[l] = 1'b1;
      end
    end
    unique case (layout)
      lsp_pkg::LSP_LAY_S12, lsp_pkg::LSP_LAY_D12: begin
        for (int l = 0; l < 6; l++) begin
          if (l < int'(lane_count)) begin
            a_next[16*l +: 16] = even_units[95 - 16*l -: 16];
            b_next[16*l +: 16] = odd_units[95 - 16*l -: 16];
          end
        end
      end
      lsp_pkg::LSP_LAY_IQ_OWN, lsp_pkg::LSP_LAY_IQ_PAIR: begin
        for (int l = 0; l < 8; l++) begin
          if (l < int'(lane_count)) begin
            if (layout == lsp_pkg::LSP_LAY_IQ_PAIR) begin
              a_next[16*l +: 16] = {inphase_samples[15*l +: 15],
                                    inphase_overrange_flag[l/2]};
              b_next[16*l +: 16] = {quadrature_samples[15*l +: 15],
                                    quadrature_overrange_flag[l/2]};
            end else begin
              a_next[16*l +: 16] = {inphase_samples[15*l +: 15],
                                    inphase_overrange_flag[l]};
              b_next[16*l +: 16] = {quadrature_samples[15*l +: 15],
                                    quadrature_overrange_flag[l]};
            end
          end
        end
      end
      lsp_pkg::LSP_LAY_S8: begin
        a_next[7:0] = samples_8[7:0];
        a_next[23:16] = samples_8[23:16];
        b_next[7:0] = samples_8[15:8];
        b_next[23:16] = samples_8[31:24];
      end
      default: begin
        a_next = '0;
        b_next = '0;
      end
    endcase
  end
  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= 7'h00;
      a_reg <= '0;
      b_reg <= '0;
      valid_reg <= 1'b0;
      active_reg <= 8'h00;
    end else begin
      mode_reg <= mode_next;
      a_reg <= a_next;
      b_reg <= b_next;
      valid_reg <= valid_next;
      active_reg <= active_next;
    end
  end
  assign group_a_lanes = a_reg;
  assign group_b_lanes = b_reg;
  assign lanes_valid = valid_reg;
  assign lane_active = active_reg;
  // ****************************************
  // Checks
  // ****************************************
  chk_s8_lane0: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_S8) |=> group_b_lanes[7:0] == $past(samples_8[15:8]))
    else $error("8-bit lane B0 wrong");
  chk_s8_lane1: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_S8) |=> group_a_lanes[23:16] == $past(samples_8[23:16]))
    else $error("8-bit lane A1 wrong");
  chk_s8_lane3: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_S8) |=> group_b_lanes[23:16] == $past(samples_8[31:24]))
    else $error("8-bit lane B1 wrong");
  chk_iq_flag_lsb: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_IQ_OWN) |=> group_a_lanes[0] == $past(inphase_overrange_flag[0]))
    else $error("I flag not in LSB");
  chk_iq_upper: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_IQ_OWN) |=> group_b_lanes[15:1] == $past(quadrature_samples[14:0]))
    else $error("Q sample not in upper bits");
  chk_pair_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_IQ_PAIR) |=> group_a_lanes[16] == $past(inphase_overrange_flag[0]))
    else $error("Pair flag index wrong");
  chk_own_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_IQ_OWN && lane_count == 4'h8)
      |=> group_b_lanes[112] == $past(quadrature_overrange_flag[7]))
    else $error("Own flag index wrong");
  chk_s12_first: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_S12) |=> group_b_lanes[15:4] == $past(samples_12[23:12]))
    else $error("Odd sample 1 misplaced");
  chk_s12_split: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_S12)
      |=> {group_a_lanes[3:0], group_a_lanes[31:24]} == $past(samples_12[35:24]))
    else $error("Split sample wrong");
  chk_d12_chan_b: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_D12) |=> group_b_lanes[15:4] == $past(samples_12[107:96]))
    else $error("Channel B sample 0 misplaced");
  chk_unused_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (layout == lsp_pkg::LSP_LAY_IQ_OWN && lane_count == 4'h1) |=> group_a_lanes[127:16] == '0)
    else $error("Unused lanes not zero");
  chk_mode_static: assert property (@(posedge clk) disable iff (!rst_b)
    lanes_valid && $past(lanes_valid) |-> $stable(mode_reg))
    else $error("Mode changed while running");
endmodule
`default_nettype wire

// ---- core/lsp_unit_pack.sv ----
// Packs eight 12-bit values contiguously, MSB first, into six 16-bit lane units.
// Assumes purely combinational use by the frame mapper.
`timescale 1ns/10ps
`default_nettype none
module lsp_unit_pack (
  input wire logic [95:0] words,
  output logic [95:0] units
);
  // ****************************************
  // Contiguous concatenation
  // ****************************************
  // words[95:84] is value 0; units[95:80] is lane 0
  always_comb begin
    units = words;
  end
endmodule
`default_nettype wire

// ---- test/lsp_lane_receiver.sv ----
// Far-side lane receiver model: counts the frames it accepts.
// Assumes one frame clock shared with the packer.
`timescale 1ns/10ps
`default_nettype none
module lsp_lane_receiver (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] cfg_mode,
  input wire logic [6:0] link_mode,
  input wire logic lanes_valid,
  output logic [15:0] frame_count
);
  // ****************************************
  // Frame acceptance
  // ****************************************
  logic [15:0] count_reg;
  logic [15:0] count_next;
  always_comb begin
    count_next = count_reg;
    if (lanes_valid && (cfg_mode == link_mode)) begin
      count_next = count_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_next;
    end
  end
  assign frame_count = count_reg;
endmodule
`default_nettype wire

// ---- test/test_lane_sample_packer.sv ----
// Self-checking bench for the lane sample packer and a far-side receiver.
// Assumes a 40 MHz frame clock; inputs change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module test_lane_sample_packer;
  typedef struct {logic [6:0] mode; int kind; int n;} lsp_row_t;
  logic clk = 1'b0;
  logic rst_b;
  logic [6:0] mode;
  logic [6:0] rx_cfg;
  logic [191:0] s12;
  logic [127:0] s8;
  logic [119:0] iq_i, iq_q;
  logic [7:0] fl_i, fl_q;
  logic valid;
  logic [127:0] lanes_a, lanes_b;
  logic lanes_valid;
  logic [7:0] lane_active;
  logic [15:0] frame_count;
  int bad_count = 0;
  int tests_run = 0;
  // Mode, layout kind (0 s12, 1 d12, 2 iq, 3 iq pair, 4 s8, 5 none), lanes per group
  lsp_row_t rows [27] = '{'{7'h13,0,6}, '{7'h2A,0,6}, '{7'h14,1,6}, '{7'h2B,1,6},
    '{7'h15,2,2}, '{7'h24,2,2}, '{7'h16,2,4}, '{7'h2E,2,4}, '{7'h17,2,1}, '{7'h26,2,1},
    '{7'h3D,2,1}, '{7'h40,2,1}, '{7'h45,2,1}, '{7'h47,2,1}, '{7'h18,2,2}, '{7'h30,2,2},
    '{7'h3E,2,2}, '{7'h41,2,2}, '{7'h46,2,2}, '{7'h19,3,8}, '{7'h34,3,8}, '{7'h1A,2,4},
    '{7'h36,2,4}, '{7'h3F,2,4}, '{7'h1B,2,8}, '{7'h20,0,3}, '{7'h21,1,3}};
  always #12.5 clk = ~clk;
  lsp_frame_mapper u_lsp_frame_mapper (.clk(clk), .rst_b(rst_b),
    .lane_packing_mode_select(mode), .samples_12(s12), .samples_8(s8),
    .inphase_samples(iq_i), .quadrature_samples(iq_q), .inphase_overrange_flag(fl_i),
    .quadrature_overrange_flag(fl_q), .sample_valid(valid), .group_a_lanes(lanes_a),
    .group_b_lanes(lanes_b), .lanes_valid(lanes_valid), .lane_active(lane_active));
  lsp_lane_receiver u_lsp_lane_receiver (.clk(clk), .rst_b(rst_b), .cfg_mode(rx_cfg),
    .link_mode(mode), .lanes_valid(lanes_valid), .frame_count(frame_count));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check_vec(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_vec({127'h0, got}, {127'h0, exp});
  endtask
  task automatic set_data(input int i);
    s12 = {6{32'h9E3779B9 + 32'(i)}};
    s8 = {4{32'h1357BDF1 ^ 32'(i)}};
    iq_i = {15{8'h5A ^ 8'(i)}};
    iq_q = {15{8'hC3 + 8'(i)}};
    fl_i = 8'hA5 ^ 8'(i);
    fl_q = 8'h3C + 8'(i);
  endtask
  function automatic logic [255:0] expect_frame(input int kind, input int n);
    logic [95:0] wa, wb;
    logic [127:0] a, b;
    a = '0;
    b = '0;
    for (int k = 0; k < 8; k++) begin
      wa[95-12*k -: 12] = (kind == 0) ? s12[24*k +: 12] : s12[12*k +: 12];
      wb[95-12*k -: 12] = (kind == 0) ? s12[24*k+12 +: 12] : s12[96+12*k +: 12];
    end
    for (int l = 0; l < n; l++) begin
      if (kind < 2) begin
        a[16*l +: 16] = wa[95-16*l -: 16];
        b[16*l +: 16] = wb[95-16*l -: 16];
      end else if (kind < 4) begin
        a[16*l +: 16] = {iq_i[15*l +: 15], fl_i[(kind == 3) ? l / 2 : l]};
        b[16*l +: 16] = {iq_q[15*l +: 15], fl_q[(kind == 3) ? l / 2 : l]};
      end
    end
    if (kind == 4) begin
      a[31:0] = {8'h00, s8[23:16], 8'h00, s8[7:0]};
      b[31:0] = {8'h00, s8[31:24], 8'h00, s8[15:8]};
    end
    return {b, a};
  endfunction
  task automatic run_row(input lsp_row_t r, input int seed, input int frames);
    logic [255:0] exp;
    @(negedge clk);
    mode = r.mode;
    rx_cfg = r.mode;
    repeat (2) @(negedge clk);
    for (int f = 0; f < frames; f++) begin
      set_data(seed + f);
      valid = 1'b1;
      @(negedge clk);
      exp = expect_frame(r.kind, r.n);
      check_vec(lanes_a, exp[127:0]);
      check_vec(lanes_b, exp[255:128]);
      check_vec({120'h0, lane_active}, {120'h0, 8'((1 << r.n) - 1)});
      check_flag(lanes_valid, r.kind != 5);
    end
    valid = 1'b0;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    mode = 7'h00;
    rx_cfg = 7'h00;
    valid = 1'b0;
    set_data(0);
    repeat (3) @(negedge clk);
    check_vec(lanes_a, 128'h0);
    check_flag(lanes_valid, 1'b0);
    rst_b = 1'b1;
    foreach (rows[i]) run_row(rows[i], i, 1);
    run_row('{7'h21, 1, 3}, 40, 3);
    @(negedge clk);
    check_vec({112'h0, frame_count}, 128'h1E);
    valid = 1'b1;
    @(negedge clk);
    rst_b = 1'b0;
    #1;
    check_vec(lanes_b, 128'h0);
    check_flag(lanes_valid, 1'b0);
    valid = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    run_row('{7'h00, 5, 0}, 50, 2);
    run_row('{7'h22, 4, 2}, 60, 1);
    @(negedge clk);
    check_vec({112'h0, frame_count}, 128'h1);
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("ERROR t=%0t got=%0h exp=%0h", $time, tests_run, 0);
    end_sim;
  end
endmodule
`default_nettype wire
